// File: rtl/modem_ctrl_pkg.sv
package modem_ctrl_pkg;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_MSR = 3'h6;

    // ------------------------------------------------------------
    // modem_line_control field positions
    // ------------------------------------------------------------
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_FIFO_RDY = 2;
    localparam int MCR_IRQ_OP = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_XON_ANY = 5;
    localparam int MCR_TCR_EN = 6;
    localparam int MCR_CLK_DIV4 = 7;

    // ------------------------------------------------------------
    // interrupt_source_enable field positions
    // ------------------------------------------------------------
    localparam int IER_RHR = 0;
    localparam int IER_THR = 1;
    localparam int IER_RLS = 2;
    localparam int IER_MODEM = 3;
    localparam int IER_SLEEP = 4;
    localparam int IER_XOFF = 5;
    localparam int IER_RTS = 6;
    localparam int IER_CTS = 7;

    // ------------------------------------------------------------
    // modem_line_status layout: delta flags low, levels high
    // ------------------------------------------------------------
    localparam int MSR_DELTA_LSB = 0;
    localparam int MSR_LEVEL_LSB = 4;
    localparam int LINE_CTS = 0;
    localparam int LINE_DSR = 1;
    localparam int LINE_RI = 2;
    localparam int LINE_CD = 3;

    // ------------------------------------------------------------
    // reset values and write-protect masks
    // ------------------------------------------------------------
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] MCR_PROT_MASK = 8'hE0;
    localparam logic [7:0] IER_PROT_MASK = 8'hF0;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [3:0] PIN_IDLE_N = 4'hF;
    localparam logic [3:0] LEVEL_RESET = 4'h0;

endpackage

// File: rtl/modem_input_sync.sv
`timescale 1ns/1ps
`default_nettype none

module modem_input_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // active-low modem pins, order cd ri dsr cts
    input wire logic [3:0] pins_n,
    // loop-back selection and its active-high source
    input wire logic loop_en,
    input wire logic [3:0] loop_src,
    // active-high levels and edge pulses
    output logic [3:0] level,
    output logic [3:0] change,
    output logic [3:0] trail
);
    import modem_ctrl_pkg::*;

    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [3:0] prev_ff;

    // two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= PIN_IDLE_N;
            sync_ff <= PIN_IDLE_N;
        end else begin
            meta_ff <= pins_n;
            sync_ff <= meta_ff;
        end
    end

    // complement in normal mode, control bits in loop-back
    always_comb begin
        if (loop_en) begin
            level = loop_src;
        end else begin
            level = ~sync_ff;
        end
    end

    // previous level for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= LEVEL_RESET;
        end else begin
            prev_ff <= level;
        end
    end

    // any change, and asserted-to-released (pin low to high)
    assign change = level ^ prev_ff;
    assign trail = prev_ff & ~level;

endmodule

`default_nettype wire

// File: rtl/modem_ctrl_status.sv
// Behaviour
// - loop-back feeds control bits into status, tx to rx
// - irq-op bit: interrupt driven/tristated, op low/high
// - fifo-ready register enabled only by bit 2
// - rts pin follows bit 1 unless auto-rts
// - dtr pin follows bit 0, dsr in loop
// - control bits 7..5 writable only when enhanced
// - normal mode status shows complemented modem inputs
// - loop-back status equals control bits 3,2,0,1
// - cd change sets delta flag, read clears
// - ri trailing edge sets flag, read clears
// - dsr change sets delta flag, read clears
// - cts change sets delta flag, read clears
// - enable bits 7,6 gate cts/rts interrupts
// - enable bit 5 gates xoff interrupt
// - enable bit 4 allows sleep mode
// - bits 3,2 gate modem and line interrupts
// - bits 1,0 gate transmit and receive interrupts
// - enable bits 7..4 writable only when enhanced
// - re-enabling transmit interrupt below threshold raises fresh one
// - interrupt asserted while irq-op bit set and any enabled source pends
// - enhanced bit acts only as write permission
`timescale 1ns/1ps
`default_nettype none

module modem_ctrl_status (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // parallel register bus
    input wire logic [modem_ctrl_pkg::ADDR_W-1:0] ADDR,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [modem_ctrl_pkg::DATA_W-1:0] WDATA,
    output logic [modem_ctrl_pkg::DATA_W-1:0] RDATA,
    output logic RD_VALID,
    // write permission from the enhanced feature control
    input wire logic ENH_WR_EN,
    // modem pins, all active low
    input wire logic CTS_N,
    input wire logic DSR_N,
    input wire logic CD_N,
    input wire logic RI_N,
    output logic RTS_N,
    output logic DTR_N,
    // hardware flow control
    input wire logic AUTO_RTS_EN,
    input wire logic FLOW_RTS_N,
    // serial path
    input wire logic TX_SERIAL,
    input wire logic RX_PIN,
    output logic TX_PIN,
    output logic RX_SERIAL,
    // interrupt sources from the rest of the channel
    input wire logic RLS_PEND,
    input wire logic RHR_PEND,
    input wire logic THR_BELOW,
    input wire logic THR_EVT,
    input wire logic THR_CLR,
    input wire logic XOFF_PEND,
    input wire logic CTS_RISE_PEND,
    input wire logic RTS_RISE_PEND,
    // interrupt pin and general output
    output logic INT_OUT,
    output logic INT_OE_N,
    output logic OP_N,
    // per-source pending flags for the priority encoder
    output logic MODEM_INT_PEND,
    output logic THR_INT_PEND,
    // control outputs to the rest of the channel
    output logic FIFO_RDY_EN,
    output logic LOOP_EN,
    output logic XON_ANY_EN,
    output logic TCR_TLR_EN,
    output logic CLK_DIV4,
    output logic SLEEP_EN
);
    import modem_ctrl_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] mcr_ff;
    logic [7:0] ier_ff;
    logic [3:0] delta_ff;
    logic [3:0] nxt_delta;
    logic thr_pend_ff;
    logic nxt_thr_pend;
    logic [7:0] rdata_ff;
    logic rd_valid_ff;
    logic [7:0] nxt_rdata;
    logic wr_mcr;
    logic wr_ier;
    logic rd_msr;
    logic loop_on;
    logic [3:0] loop_src;
    logic [3:0] line_level;
    logic [3:0] line_change;
    logic [3:0] line_trail;
    logic [3:0] delta_set;
    logic [7:0] msr_value;
    logic [7:0] nxt_ier;
    logic modem_pend;
    logic any_pend;
    logic int_ff;
    logic int_oe_n_ff;
    logic op_n_ff;
    logic rts_n_ff;
    logic dtr_n_ff;
    logic tx_pin_ff;
    logic rx_serial_ff;
    logic modem_pend_ff;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // merge a write, keeping protected bits unless permitted
    function automatic logic [7:0] guarded_write(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] prot_mask,
        input logic permit
    );
        logic [7:0] keep;
        keep = permit ? 8'h00 : prot_mask;
        guarded_write = (old_val & keep) | (new_val & ~keep);
    endfunction

    // address match for a bus strobe
    function automatic logic hit(
        input logic stb,
        input logic [2:0] addr,
        input logic [2:0] target
    );
        hit = stb && (addr == target);
    endfunction

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------

    // one strobe per access, unmapped addresses ignored
    assign wr_mcr = hit(WR_STB, ADDR, ADDR_MCR);
    assign wr_ier = hit(WR_STB, ADDR, ADDR_IER);
    assign rd_msr = hit(RD_STB, ADDR, ADDR_MSR);

    // ------------------------------------------------------------
    // modem_line_control
    // ------------------------------------------------------------

    // upper bits need enhanced write permission
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mcr_ff <= MCR_RESET;
        end else if (wr_mcr) begin
            mcr_ff <= guarded_write(mcr_ff, WDATA, MCR_PROT_MASK, ENH_WR_EN);
        end
    end

    assign loop_on = mcr_ff[MCR_LOOP];

    // ------------------------------------------------------------
    // interrupt_source_enable
    // ------------------------------------------------------------

    // upper bits need enhanced write permission
    assign nxt_ier = guarded_write(ier_ff, WDATA, IER_PROT_MASK, ENH_WR_EN);

    // all enables reset to disabled
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ier_ff <= IER_RESET;
        end else if (wr_ier) begin
            ier_ff <= nxt_ier;
        end
    end

    // ------------------------------------------------------------
    // modem inputs and change detection
    // ------------------------------------------------------------

    // loop-back sources in cd ri dsr cts order
    assign loop_src = {mcr_ff[MCR_IRQ_OP], mcr_ff[MCR_FIFO_RDY], mcr_ff[MCR_DTR], mcr_ff[MCR_RTS]};

    modem_input_sync u_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .pins_n({CD_N, RI_N, DSR_N, CTS_N}),
        .loop_en(loop_on),
        .loop_src(loop_src),
        .level(line_level),
        .change(line_change),
        .trail(line_trail)
    );

    // cd, dsr, cts flag any change; ri flags only its trailing edge
    always_comb begin
        delta_set = line_change;
        delta_set[LINE_CD] = line_change[LINE_CD];
        delta_set[LINE_DSR] = line_change[LINE_DSR];
        delta_set[LINE_CTS] = line_change[LINE_CTS];
        delta_set[LINE_RI] = line_trail[LINE_RI];
    end

    // read clears, a new edge in the same cycle wins
    always_comb begin
        nxt_delta = delta_ff;
        if (rd_msr) begin
            nxt_delta = 4'h0;
        end
        nxt_delta = nxt_delta | delta_set;
    end

    // sticky delta flags
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            delta_ff <= 4'h0;
        end else begin
            delta_ff <= nxt_delta;
        end
    end

    // status image: levels high, deltas low
    assign msr_value = {line_level, delta_ff};

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------

    // mux for the three mapped registers, zero elsewhere
    always_comb begin
        case (ADDR)
            ADDR_MCR: nxt_rdata = mcr_ff;
            ADDR_IER: nxt_rdata = ier_ff;
            ADDR_MSR: nxt_rdata = msr_value;
            default: nxt_rdata = RDATA_RESET;
        endcase
    end

    // data registered one cycle after the read strobe
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_ff <= RDATA_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= RD_STB;
            if (RD_STB) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt sources
    // ------------------------------------------------------------

    // modem interrupt while any flag set and enabled
    assign modem_pend = ier_ff[IER_MODEM] && (delta_ff != 4'h0);

    // transmit holding pending: event or re-enable below threshold
    always_comb begin
        nxt_thr_pend = thr_pend_ff;
        if (THR_CLR) begin
            nxt_thr_pend = 1'b0;
        end
        if (THR_EVT) begin
            nxt_thr_pend = 1'b1;
        end
        if (wr_ier && !ier_ff[IER_THR] && nxt_ier[IER_THR] && THR_BELOW) begin
            nxt_thr_pend = 1'b1;
        end
    end

    // sticky transmit holding source
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            thr_pend_ff <= 1'b0;
        end else begin
            thr_pend_ff <= nxt_thr_pend;
        end
    end

    // each source gated by its own enable bit
    assign any_pend = (ier_ff[IER_RLS] && RLS_PEND)
        || (ier_ff[IER_RHR] && RHR_PEND)
        || (ier_ff[IER_THR] && thr_pend_ff)
        || modem_pend
        || (ier_ff[IER_XOFF] && XOFF_PEND)
        || (ier_ff[IER_CTS] && CTS_RISE_PEND)
        || (ier_ff[IER_RTS] && RTS_RISE_PEND);

    // ------------------------------------------------------------
    // interrupt pin and general output
    // ------------------------------------------------------------

    // enable off: pin released, op high; on: pin driven, op low
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            int_ff <= 1'b0;
            int_oe_n_ff <= 1'b1;
            op_n_ff <= 1'b1;
        end else begin
            int_ff <= mcr_ff[MCR_IRQ_OP] && any_pend;
            int_oe_n_ff <= ~mcr_ff[MCR_IRQ_OP];
            op_n_ff <= ~mcr_ff[MCR_IRQ_OP];
        end
    end

    // pending flags handed to the priority encoder
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            modem_pend_ff <= 1'b0;
        end else begin
            modem_pend_ff <= modem_pend;
        end
    end

    // ------------------------------------------------------------
    // modem control outputs
    // ------------------------------------------------------------

    // rts from flow control when automatic, else the control bit
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rts_n_ff <= 1'b1;
            dtr_n_ff <= 1'b1;
        end else begin
            if (AUTO_RTS_EN) begin
                rts_n_ff <= FLOW_RTS_N;
            end else begin
                rts_n_ff <= ~mcr_ff[MCR_RTS];
            end
            dtr_n_ff <= ~mcr_ff[MCR_DTR];
        end
    end

    // ------------------------------------------------------------
    // serial loop-back
    // ------------------------------------------------------------

    // in loop-back tx idles high and rx hears our own tx
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_pin_ff <= 1'b1;
            rx_serial_ff <= 1'b1;
        end else begin
            if (loop_on) begin
                tx_pin_ff <= 1'b1;
                rx_serial_ff <= TX_SERIAL;
            end else begin
                tx_pin_ff <= TX_SERIAL;
                rx_serial_ff <= RX_PIN;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign RDATA = rdata_ff;
    assign RD_VALID = rd_valid_ff;
    assign RTS_N = rts_n_ff;
    assign DTR_N = dtr_n_ff;
    assign TX_PIN = tx_pin_ff;
    assign RX_SERIAL = rx_serial_ff;
    assign INT_OUT = int_ff;
    assign INT_OE_N = int_oe_n_ff;
    assign OP_N = op_n_ff;
    assign MODEM_INT_PEND = modem_pend_ff;
    assign THR_INT_PEND = thr_pend_ff;

    // straight from the control registers
    assign FIFO_RDY_EN = mcr_ff[MCR_FIFO_RDY];
    assign LOOP_EN = mcr_ff[MCR_LOOP];
    assign XON_ANY_EN = mcr_ff[MCR_XON_ANY];
    assign TCR_TLR_EN = mcr_ff[MCR_TCR_EN];
    assign CLK_DIV4 = mcr_ff[MCR_CLK_DIV4];
    assign SLEEP_EN = ier_ff[IER_SLEEP];

endmodule

`default_nettype wire

// File: test/modem_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// modem side of the status lines
// ----------------------------------------
module modem_peer_model (
    // command, order cd ri dsr cts, low = asserted
    input wire logic [3:0] want_n,
    // modem lines
    output logic cts_n,
    output logic dsr_n,
    output logic ri_n,
    output logic cd_n
);
    // lines idle high, then move a few ns off the clock edge
    initial {cd_n, ri_n, dsr_n, cts_n} = 4'hF;
    always @(want_n) {cd_n, ri_n, dsr_n, cts_n} <= #3 want_n;
endmodule
`default_nettype wire

// File: test/modem_ctrl_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module modem_ctrl_status_properties (
    // clock, reset, bus
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [modem_ctrl_pkg::ADDR_W-1:0] ADDR,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [modem_ctrl_pkg::DATA_W-1:0] WDATA,
    input wire logic RD_VALID,
    input wire logic ENH_WR_EN,
    // pins and controls
    input wire logic RTS_N,
    input wire logic DTR_N,
    input wire logic AUTO_RTS_EN,
    input wire logic FLOW_RTS_N,
    input wire logic TX_SERIAL,
    input wire logic RX_PIN,
    input wire logic TX_PIN,
    input wire logic RX_SERIAL,
    input wire logic INT_OUT,
    input wire logic INT_OE_N,
    input wire logic OP_N,
    input wire logic MODEM_INT_PEND,
    input wire logic FIFO_RDY_EN,
    input wire logic LOOP_EN,
    input wire logic XON_ANY_EN,
    input wire logic TCR_TLR_EN,
    input wire logic CLK_DIV4,
    input wire logic SLEEP_EN
);
    import modem_ctrl_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // write decodes
    wire mcr_wr = WR_STB && ADDR == ADDR_MCR;
    wire ier_wr = WR_STB && ADDR == ADDR_IER;
    a_op_irq_pair: assert property (OP_N == INT_OE_N)
        else $error("op level and interrupt enable differ");
    a_irq_tristate: assert property (INT_OE_N |-> !INT_OUT)
        else $error("interrupt active while pin released");
    a_dtr_follows: assert property (mcr_wr |-> ##2 DTR_N == !$past(WDATA[MCR_DTR], 2))
        else $error("dtr does not follow control bit");
    a_rts_manual: assert property ((mcr_wr && !AUTO_RTS_EN) ##1 !AUTO_RTS_EN |=>
        RTS_N == !$past(WDATA[MCR_RTS], 2)) else $error("rts does not follow control bit");
    a_rts_auto: assert property (AUTO_RTS_EN |=> RTS_N == $past(FLOW_RTS_N))
        else $error("rts ignores flow control");
    a_loop_serial: assert property (LOOP_EN |=> TX_PIN && RX_SERIAL == $past(TX_SERIAL))
        else $error("serial loop path wrong");
    a_norm_serial: assert property (!LOOP_EN |=> TX_PIN == $past(TX_SERIAL) && RX_SERIAL == $past(RX_PIN))
        else $error("serial normal path wrong");
    a_rd_valid: assert property (RD_VALID == $past(RD_STB))
        else $error("read valid timing wrong");
    a_ctl_protect: assert property ((mcr_wr && !ENH_WR_EN) |=> $stable({XON_ANY_EN, TCR_TLR_EN, CLK_DIV4}))
        else $error("protected control bits changed");
    a_ier_protect: assert property ((ier_wr && !ENH_WR_EN) |=> $stable(SLEEP_EN))
        else $error("protected enable bit changed");
    a_ctl_write: assert property ((mcr_wr && ENH_WR_EN) |=> {CLK_DIV4, TCR_TLR_EN, XON_ANY_EN, LOOP_EN,
        FIFO_RDY_EN} == $past({WDATA[7:4], WDATA[2]})) else $error("control outputs wrong");
    a_sleep_write: assert property ((ier_wr && ENH_WR_EN) |=> SLEEP_EN == $past(WDATA[IER_SLEEP]))
        else $error("sleep enable wrong");
    a_modem_irq: assert property ((MODEM_INT_PEND && !INT_OE_N) |-> INT_OUT)
        else $error("modem interrupt not driven");
endmodule
bind modem_ctrl_status modem_ctrl_status_properties modem_ctrl_status_properties_i (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB),
    .WDATA(WDATA), .RD_VALID(RD_VALID), .ENH_WR_EN(ENH_WR_EN), .RTS_N(RTS_N), .DTR_N(DTR_N),
    .AUTO_RTS_EN(AUTO_RTS_EN), .FLOW_RTS_N(FLOW_RTS_N), .TX_SERIAL(TX_SERIAL), .RX_PIN(RX_PIN),
    .TX_PIN(TX_PIN), .RX_SERIAL(RX_SERIAL), .INT_OUT(INT_OUT), .INT_OE_N(INT_OE_N), .OP_N(OP_N),
    .MODEM_INT_PEND(MODEM_INT_PEND), .FIFO_RDY_EN(FIFO_RDY_EN), .LOOP_EN(LOOP_EN),
    .XON_ANY_EN(XON_ANY_EN), .TCR_TLR_EN(TCR_TLR_EN), .CLK_DIV4(CLK_DIV4), .SLEEP_EN(SLEEP_EN));
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import modem_ctrl_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic core_clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, enh = 1'b0, auto_rts = 1'b0;
    logic flow_rts_n = 1'b1, tx_ser = 1'b1, rx_pin = 1'b1, thr_below = 1'b0, thr_evt = 1'b0, thr_clr = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [4:0] pend = 5'h00;
    logic [3:0] want_n = 4'hF;
    logic rd_valid, rts_n, dtr_n, tx_pin, rx_ser, int_out, int_oe_n, op_n, mpend, tpend;
    logic fifo_rdy, loop_en, xon_any, tcr_en, div4, sleep_en, cts_n, dsr_n, cd_n, ri_n;
    int fail_count = 0, checks = 0, cyc = 0;
    localparam logic [7:0] EN_BIT [5] = '{8'h04, 8'h01, 8'h20, 8'h80, 8'h40};
    // grouped views of the outputs
    wire [7:0] pv = {int_out, int_oe_n, op_n, rts_n, dtr_n, mpend, tpend, fifo_rdy};
    wire [7:0] cv = {div4, tcr_en, xon_any, loop_en, sleep_en, fifo_rdy, tx_pin, rx_ser};
    modem_peer_model modem_peer_model_i (.want_n(want_n), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n));
    modem_ctrl_status modem_ctrl_status_i (
        .CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .WDATA(wdata), .RDATA(rdata), .RD_VALID(rd_valid), .ENH_WR_EN(enh), .CTS_N(cts_n),
        .DSR_N(dsr_n), .CD_N(cd_n), .RI_N(ri_n), .RTS_N(rts_n), .DTR_N(dtr_n), .AUTO_RTS_EN(auto_rts),
        .FLOW_RTS_N(flow_rts_n), .TX_SERIAL(tx_ser), .RX_PIN(rx_pin), .TX_PIN(tx_pin), .RX_SERIAL(rx_ser),
        .RLS_PEND(pend[0]), .RHR_PEND(pend[1]), .THR_BELOW(thr_below), .THR_EVT(thr_evt),
        .THR_CLR(thr_clr), .XOFF_PEND(pend[2]), .CTS_RISE_PEND(pend[3]), .RTS_RISE_PEND(pend[4]),
        .INT_OUT(int_out), .INT_OE_N(int_oe_n), .OP_N(op_n), .MODEM_INT_PEND(mpend),
        .THR_INT_PEND(tpend), .FIFO_RDY_EN(fifo_rdy), .LOOP_EN(loop_en), .XON_ANY_EN(xon_any),
        .TCR_TLR_EN(tcr_en), .CLK_DIV4(div4), .SLEEP_EN(sleep_en));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always #5 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    // read one byte and compare, valid strobe included
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        chk({7'h00, rd_valid}, 8'h01);
        chk(rdata, exp);
    endtask
    // hang guard, run needs about three hundred cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        gap(2);
        chk(pv, 8'h78);
        rdc(ADDR_IER, IER_RESET);
        rdc(ADDR_MCR, MCR_RESET);
        rdc(ADDR_MSR, 8'h00);
        rdc(3'h0, 8'h00);
        wr(ADDR_MCR, 8'hE7);
        wr(3'h7, 8'hFF);
        wr(ADDR_IER, 8'hF0);
        gap(2);
        rdc(ADDR_MCR, 8'h07);
        rdc(ADDR_IER, 8'h00);
        chk(pv, 8'h61);
        @(posedge core_clk) enh <= 1'b1;
        wr(ADDR_MCR, 8'hE0);
        wr(ADDR_IER, 8'hF0);
        @(posedge core_clk) enh <= 1'b0;
        wr(ADDR_MCR, 8'h00);
        wr(ADDR_IER, 8'h00);
        rdc(ADDR_MCR, 8'hE0);
        rdc(ADDR_IER, 8'hF0);
        chk(cv, 8'hEB);
        @(posedge core_clk) enh <= 1'b1;
        wr(ADDR_IER, 8'h00);
        wr(ADDR_MCR, 8'h00);
        // each modem line asserted then released
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) want_n[i] <= 1'b0;
            gap(8);
            rdc(ADDR_MSR, (8'h10 << i) | ((i == LINE_RI) ? 8'h00 : (8'h01 << i)));
            rdc(ADDR_MSR, 8'h10 << i);
            @(posedge core_clk) want_n[i] <= 1'b1;
            gap(8);
            rdc(ADDR_MSR, 8'h01 << i);
        end
        // each of the five pend sources masked, then enabled onto the pin
        wr(ADDR_MCR, 8'h08);
        for (int j = 0; j < 5; j++) begin
            @(posedge core_clk) pend[j] <= 1'b1;
            gap(3);
            chk({7'h00, int_out}, 8'h00);
            wr(ADDR_IER, EN_BIT[j]);
            gap(3);
            chk({7'h00, int_out}, 8'h01);
            wr(ADDR_IER, 8'h00);
            pend[j] <= 1'b0;
        end
        wr(ADDR_IER, 8'h08);
        @(posedge core_clk) want_n[0] <= 1'b0;
        gap(8);
        chk(pv, 8'h9C);
        rdc(ADDR_MSR, 8'h11);
        gap(3);
        chk(pv, 8'h18);
        @(posedge core_clk) want_n[0] <= 1'b1;
        gap(8);
        wr(ADDR_MCR, 8'h00);
        gap(3);
        chk(pv, 8'h7C);
        rdc(ADDR_MSR, 8'h01);
        // transmit holding pending, cleared and re-armed
        @(posedge core_clk) thr_below <= 1'b1;
        wr(ADDR_IER, 8'h02);
        gap(2);
        chk({7'h00, tpend}, 8'h01);
        @(posedge core_clk) thr_clr <= 1'b1;
        @(posedge core_clk) thr_clr <= 1'b0;
        gap(2);
        chk({7'h00, tpend}, 8'h00);
        wr(ADDR_IER, 8'h00);
        wr(ADDR_IER, 8'h02);
        gap(2);
        chk({7'h00, tpend}, 8'h01);
        @(posedge core_clk) thr_clr <= 1'b1;
        thr_below <= 1'b0;
        @(posedge core_clk) thr_clr <= 1'b0;
        thr_evt <= 1'b1;
        @(posedge core_clk) thr_evt <= 1'b0;
        gap(2);
        chk({7'h00, tpend}, 8'h01);
        @(posedge core_clk) thr_clr <= 1'b1;
        @(posedge core_clk) thr_clr <= 1'b0;
        wr(ADDR_IER, 8'h00);
        // internal loop-back of control bits and serial path
        wr(ADDR_MCR, 8'h10);
        rdc(ADDR_MSR, 8'h00);
        wr(ADDR_MCR, 8'h1D);
        gap(5);
        rdc(ADDR_MSR, 8'hEA);
        wr(ADDR_MCR, 8'h12);
        gap(5);
        rdc(ADDR_MSR, 8'h1F);
        @(posedge core_clk) tx_ser <= 1'b0;
        gap(2);
        chk(cv, 8'h12);
        wr(ADDR_MCR, 8'h00);
        gap(2);
        chk(cv, 8'h01);
        // flow control takes the request line
        @(posedge core_clk) tx_ser <= 1'b1;
        auto_rts <= 1'b1;
        flow_rts_n <= 1'b0;
        gap(2);
        chk(pv, 8'h68);
        @(posedge core_clk) flow_rts_n <= 1'b1;
        gap(2);
        chk(pv, 8'h78);
        tally_and_finish();
    end
endmodule
`default_nettype wire
